// File: pkg/lbpc_pkg.sv
// Purpose: shared constants and types of the lane test logic
// Assumes: lane data words are on pclk, MSB sent first
// Notes: register offsets are byte addresses on APB
package lbpc_pkg;
  localparam int LANES = 4;
  localparam int DATA_W = 20;
  localparam int CNT_W = 32;
  localparam int ERR_W = $clog2(DATA_W + 1);
  localparam int ADDR_W = 8;
  localparam int LFSR_W = 31;
  localparam int SYNC_WORDS = 8;
  localparam int LK_W = 3 * LANES;
  // sequence orders
  localparam logic [2:0] ORD7 = 3'h0;
  localparam logic [2:0] ORD9 = 3'h1;
  localparam logic [2:0] ORD15 = 3'h2;
  localparam logic [2:0] ORD23 = 3'h3;
  localparam logic [2:0] ORD31 = 3'h4;
  // test modes
  localparam logic [1:0] MODE_PRBS = 2'h0;
  localparam logic [1:0] MODE_FIXED = 2'h1;
  localparam logic [1:0] MODE_MAXRUN = 2'h2;
  localparam logic [1:0] MODE_USER = 2'h3;
  // loopback selections
  localparam logic [1:0] LB_NONE = 2'h0;
  localparam logic [1:0] LB_EQUALIZER_NEAR = 2'h1;
  localparam logic [1:0] LB_EQUALIZER_FAR = 2'h2;
  localparam logic [1:0] LB_RECOVERED_CLOCK_FAR = 2'h3;
  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_USER_PAT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_LANE_CFG = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ERR_COUNT = 8'h20;
  // field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_CLEAR_LSB = 8;
  localparam int CMD_INJECT_LSB = 16;
  localparam int CFG_ORDER_LSB = 0;
  localparam int CFG_LOOP_LSB = 4;
  localparam int STAT_RUN_LSB = 0;
  localparam int STAT_FAIL_LSB = 4;
  localparam int STAT_TXL_LSB = 8;
  localparam int STAT_RXL_LSB = 12;
  localparam int STAT_DL_LSB = 16;
  localparam int STAT_SYNC_LSB = 20;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 31'h7fffffff;

  typedef struct packed {
    logic [1:0] loopback;
    logic [2:0] order;
  } lbpc_lane_cfg_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [LANES-1:0] sel;
    logic [1:0] mode;
    lbpc_lane_cfg_s [LANES-1:0] cfg;
    logic [DATA_W-1:0] user_pat;
    logic [LANES-1:0] run;
    logic [LANES-1:0] fail;
    logic [LANES-1:0] start;
    logic [LANES-1:0] inj;
    logic [LANES-1:0][CNT_W-1:0] err;
    logic [LANES-1:0][DATA_W-1:0] tx;
    logic [LANES-1:0] tx_en;
    logic [LANES-1:0] rx_en;
    logic [LK_W-1:0] lk_meta;
    logic [LK_W-1:0] lk_sync;
  } lbpc_top_s;

  // feedback bit of the standard polynomial for each order
  function automatic logic lbpc_prbs_fb(input logic [LFSR_W-1:0] s,
                                        input logic [2:0] ord);
    case (ord)
      ORD9: return s[8] ^ s[4];
      ORD15: return s[14] ^ s[13];
      ORD23: return s[22] ^ s[17];
      ORD31: return s[30] ^ s[27];
      default: return s[6] ^ s[5];
    endcase
  endfunction : lbpc_prbs_fb
endpackage : lbpc_pkg

// File: design/lbpc_prbs_gen.sv
// Purpose: word-parallel pseudo-random sequence generator
// Assumes: load has priority over enable
// Notes: word MSB is the earliest bit of the sequence
module lbpc_prbs_gen #(
  parameter int DW = lbpc_pkg::DATA_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic load,
  input wire logic enable,
  input wire logic [2:0] order,
  // sequence word
  output logic [DW-1:0] word
);
  typedef struct packed {
    logic [lbpc_pkg::LFSR_W-1:0] lfsr;
    logic [DW-1:0] word;
  } lbpc_gen_s;

  lbpc_gen_s r, n;

  initial begin
    if (DW < 2) $error("lbpc_prbs_gen: DW too small");
  end

  always_comb begin
    logic fb;
    fb = 1'b0;
    n = r;
    if (load) begin
      n.lfsr = lbpc_pkg::LFSR_SEED;
    end else if (enable) begin
      for (int b = DW - 1; b >= 0; b--) begin
        fb = lbpc_pkg::lbpc_prbs_fb(n.lfsr, order);
        n.word[b] = fb;
        n.lfsr = {n.lfsr[lbpc_pkg::LFSR_W-2:0], fb};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign word = r.word;
endmodule : lbpc_prbs_gen

// File: design/lbpc_prbs_chk.sv
// Purpose: self-synchronising sequence checker
// Assumes: rx_word is on pclk, MSB is the earliest bit
// Notes: seeds from received bits, then free-runs once locked
module lbpc_prbs_chk #(
  parameter int DW = lbpc_pkg::DATA_W,
  parameter int SYNC_WORDS = lbpc_pkg::SYNC_WORDS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic enable,
  input wire logic [2:0] order,
  input wire logic [DW-1:0] rx_word,
  // result
  output logic [$clog2(DW+1)-1:0] err_bits,
  output logic locked
);
  localparam int EW = $clog2(DW + 1);
  localparam int CW = $clog2(SYNC_WORDS + 1);

  typedef struct packed {
    logic [lbpc_pkg::LFSR_W-1:0] lfsr;
    logic [CW-1:0] clean;
    logic locked;
    logic [EW-1:0] errs;
  } lbpc_chk_s;

  lbpc_chk_s r, n;

  initial begin
    if (SYNC_WORDS < 1) $error("lbpc_prbs_chk: SYNC_WORDS < 1");
  end

  always_comb begin
    logic p;
    logic [EW-1:0] mism;
    p = 1'b0;
    mism = '0;
    n = r;
    n.errs = '0;
    for (int b = DW - 1; b >= 0; b--) begin
      p = lbpc_pkg::lbpc_prbs_fb(n.lfsr, order);
      mism = mism + EW'(rx_word[b] ^ p);
      n.lfsr = {n.lfsr[lbpc_pkg::LFSR_W-2:0], r.locked ? p : rx_word[b]};
    end
    if (!enable) begin
      n.locked = 1'b0;
      n.clean = '0;
    end else if (r.locked) begin
      n.errs = mism;
    end else if (mism != '0 || n.lfsr == '0) begin
      // an all-zero history is no sequence: never lock on a dead line
      n.clean = '0;
    end else if (r.clean == CW'(SYNC_WORDS - 1)) begin
      n.locked = 1'b1;
    end else begin
      n.clean = r.clean + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign err_bits = r.errs;
  assign locked = r.locked;
endmodule : lbpc_prbs_chk

// File: design/lbpc_top.sv
// Purpose: lane sequence test, static pattern and loopback control
// Assumes: APB slave on pclk, zero-wait answer one cycle after setup
// Notes: lock inputs are asynchronous pins and are synchronised
//
// The implementer's own choices: the APB register port and the address map.
module lbpc_top #(
  parameter int SYNC_WORDS = lbpc_pkg::SYNC_WORDS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [lbpc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // lane data
  input wire logic [lbpc_pkg::LANES-1:0][lbpc_pkg::DATA_W-1:0] rx_data,
  output logic [lbpc_pkg::LANES-1:0][lbpc_pkg::DATA_W-1:0] tx_data,
  output logic [lbpc_pkg::LANES-1:0] tx_enable,
  output logic [lbpc_pkg::LANES-1:0] rx_enable,
  output logic [lbpc_pkg::LANES-1:0][1:0] loopback_sel,
  // lock pins
  input wire logic [lbpc_pkg::LANES-1:0] tx_pll_lock,
  input wire logic [lbpc_pkg::LANES-1:0] rx_pll_lock,
  input wire logic [lbpc_pkg::LANES-1:0] receive_data_lock
);
  localparam int L = lbpc_pkg::LANES;
  localparam int DW = lbpc_pkg::DATA_W;
  localparam int CW = lbpc_pkg::CNT_W;
  localparam int EW = lbpc_pkg::ERR_W;

  lbpc_pkg::lbpc_top_s r, n;
  logic [L-1:0][DW-1:0] gen_word;
  logic [L-1:0][EW-1:0] chk_err;
  logic [L-1:0] chk_lock;
  logic [L-1:0] prbs_on;

  initial begin
    if (L < 1 || L > 4) begin
      $error("lbpc_top: one to four lanes per core");
    end
    if (DW < 2 || DW > 32 || DW % 2 != 0) begin
      $error("lbpc_top: DATA_W must be even and 2..32");
    end
    if (SYNC_WORDS < 1) begin
      $error("lbpc_top: SYNC_WORDS must be at least 1");
    end
  end

  // accepted write that sets one bit of the command register
  function automatic logic cmd_bit(input logic wr,
                                   input logic [lbpc_pkg::ADDR_W-1:0] a,
                                   input logic [31:0] d,
                                   input int pos);
    return wr && a == lbpc_pkg::ADDR_COMMAND && d[pos];
  endfunction : cmd_bit

  // aligned word of a per-lane window with a lane behind it
  function automatic logic lane_hit(input logic [lbpc_pkg::ADDR_W-1:0] a,
                                    input logic [lbpc_pkg::ADDR_W-1:0] base);
    logic [1:0] lane;
    lane = a[3:2];
    return a[7:4] == base[7:4] && a[1:0] == 2'h0
           && 32'(lane) < lbpc_pkg::LANES;
  endfunction : lane_hit

  // lanes that currently run the pseudo-random sequence
  always_comb begin
    for (int l = 0; l < L; l++) begin
      prbs_on[l] = r.run[l] & (r.mode == lbpc_pkg::MODE_PRBS);
    end
  end

  genvar g;
  generate
    for (g = 0; g < L; g++) begin : g_lane
      lbpc_prbs_gen #(
        .DW(DW)
      ) u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .load(r.start[g]),
        .enable(prbs_on[g]),
        .order(r.cfg[g].order),
        .word(gen_word[g])
      );
      lbpc_prbs_chk #(
        .DW(DW),
        .SYNC_WORDS(SYNC_WORDS)
      ) u_chk (
        .pclk(pclk),
        .presetn(presetn),
        .enable(prbs_on[g]),
        .order(r.cfg[g].order),
        .rx_word(rx_data[g]),
        .err_bits(chk_err[g]),
        .locked(chk_lock[g])
      );
    end
  endgenerate

  always_comb begin
    logic setup;
    logic done;
    logic wr;
    logic known;
    logic [1:0] idx;
    logic [L-1:0] txl;
    logic [L-1:0] rxl;
    logic [L-1:0] dl;
    logic [31:0] rd;
    logic [CW:0] sum;
    logic [DW-1:0] fixed;
    logic [DW-1:0] maxrun;
    logic do_start;
    logic do_stop;
    setup = psel & ~penable;
    done = psel & penable & r.pready;
    wr = done & pwrite;
    idx = paddr[3:2];
    txl = r.lk_sync[L-1:0];
    rxl = r.lk_sync[2*L-1:L];
    dl = r.lk_sync[3*L-1:2*L];
    known = 1'b0;
    rd = '0;
    sum = '0;
    for (int b = 0; b < DW; b++) begin
      fixed[b] = ((DW - 1 - b) % 2) == 0;
      maxrun[b] = b >= DW / 2;
    end
    do_start = cmd_bit(wr, paddr, pwdata, lbpc_pkg::CMD_START_BIT);
    do_stop = cmd_bit(wr, paddr, pwdata, lbpc_pkg::CMD_STOP_BIT);
    n = r;
    // lock pins come from the transceiver clocks: two flops first
    n.lk_meta = {receive_data_lock, rx_pll_lock, tx_pll_lock};
    n.lk_sync = r.lk_meta;
    n.start = '0;
    n.inj = '0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // read decode, answered in the cycle after setup
    unique case (paddr)
      lbpc_pkg::ADDR_CONTROL: begin
        known = 1'b1;
        rd[lbpc_pkg::CTRL_SEL_LSB +: L] = r.sel;
        rd[lbpc_pkg::CTRL_MODE_LSB +: 2] = r.mode;
      end
      lbpc_pkg::ADDR_COMMAND: begin
        // write-only: reads return zero
        known = 1'b1;
      end
      lbpc_pkg::ADDR_STATUS: begin
        known = 1'b1;
        rd[lbpc_pkg::STAT_RUN_LSB +: L] = r.run;
        rd[lbpc_pkg::STAT_FAIL_LSB +: L] = r.fail;
        rd[lbpc_pkg::STAT_TXL_LSB +: L] = txl;
        rd[lbpc_pkg::STAT_RXL_LSB +: L] = rxl;
        rd[lbpc_pkg::STAT_DL_LSB +: L] = dl;
        rd[lbpc_pkg::STAT_SYNC_LSB +: L] = chk_lock;
      end
      lbpc_pkg::ADDR_USER_PAT: begin
        known = 1'b1;
        rd[DW-1:0] = r.user_pat;
      end
      default: begin
        if (lane_hit(paddr, lbpc_pkg::ADDR_LANE_CFG)) begin
          known = 1'b1;
          rd[lbpc_pkg::CFG_ORDER_LSB +: 3] = r.cfg[idx].order;
          rd[lbpc_pkg::CFG_LOOP_LSB +: 2] = r.cfg[idx].loopback;
        end else if (lane_hit(paddr, lbpc_pkg::ADDR_ERR_COUNT)) begin
          known = 1'b1;
          rd[CW-1:0] = r.err[idx];
        end
      end
    endcase

    // answer in the access cycle: pready is a one-cycle pulse
    if (setup) begin
      n.pready = 1'b1;
      n.pslverr = ~known;
      n.prdata = pwrite ? 32'h0000_0000 : rd;
    end

    // register writes take effect at the completing edge
    if (wr && known) begin
      if (paddr == lbpc_pkg::ADDR_CONTROL) begin
        n.sel = pwdata[lbpc_pkg::CTRL_SEL_LSB +: L];
        n.mode = pwdata[lbpc_pkg::CTRL_MODE_LSB +: 2];
      end else if (paddr == lbpc_pkg::ADDR_USER_PAT) begin
        n.user_pat = pwdata[DW-1:0];
      end else if (lane_hit(paddr, lbpc_pkg::ADDR_LANE_CFG)) begin
        n.cfg[idx].order = pwdata[lbpc_pkg::CFG_ORDER_LSB +: 3];
        n.cfg[idx].loopback = pwdata[lbpc_pkg::CFG_LOOP_LSB +: 2];
      end
    end

    for (int l = 0; l < L; l++) begin
      // start and stop
      if (do_stop) begin
        n.run[l] = 1'b0;
      end else if (do_start && r.sel[l]) begin
        // a lane without transmit lock or with an order above ORD31 stays off; the others still start
        n.fail[l] = ~txl[l] | (r.cfg[l].order > lbpc_pkg::ORD31);
        n.run[l] = ~n.fail[l];
        n.start[l] = ~n.fail[l];
      end
      n.tx_en[l] = n.run[l];
      n.rx_en[l] = n.run[l] && r.mode == lbpc_pkg::MODE_PRBS;

      // one-shot error injection on a running sequence lane
      if (cmd_bit(wr, paddr, pwdata, lbpc_pkg::CMD_INJECT_LSB + l)
          && prbs_on[l]) begin
        n.inj[l] = 1'b1;
      end

      // error counter: a new count in the clear cycle is kept
      sum = {1'b0, r.err[l]};
      if (cmd_bit(wr, paddr, pwdata, lbpc_pkg::CMD_CLEAR_LSB + l)) begin
        sum = '0;
      end
      if (prbs_on[l]) begin
        sum = sum + (CW + 1)'(chk_err[l]);
      end
      n.err[l] = sum[CW] ? {CW{1'b1}} : sum[CW-1:0];

      // transmit word
      if (r.cfg[l].loopback == lbpc_pkg::LB_RECOVERED_CLOCK_FAR) begin
        // the far end's words leave again, running or not
        n.tx[l] = rx_data[l];
      end else if (!r.run[l]) begin
        n.tx[l] = '0;
      end else begin
        unique case (r.mode)
          lbpc_pkg::MODE_PRBS: begin
            n.tx[l] = gen_word[l] ^ {{(DW-1){1'b0}}, r.inj[l]};
          end
          lbpc_pkg::MODE_FIXED: begin
            n.tx[l] = fixed;
          end
          lbpc_pkg::MODE_MAXRUN: begin
            n.tx[l] = maxrun;
          end
          lbpc_pkg::MODE_USER: begin
            n.tx[l] = r.user_pat;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      for (int l = 0; l < L; l++) begin
        r.cfg[l].order <= lbpc_pkg::ORD7;
        r.cfg[l].loopback <= lbpc_pkg::LB_NONE;
      end
      r.mode <= lbpc_pkg::MODE_PRBS;
    end else begin
      r <= n;
    end
  end

  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign tx_data = r.tx;
  assign tx_enable = r.tx_en;
  assign rx_enable = r.rx_en;

  // loopback selection goes straight to the lane
  always_comb begin
    for (int l = 0; l < L; l++) begin
      loopback_sel[l] = r.cfg[l].loopback;
    end
  end
endmodule : lbpc_top

// File: verification/lbpc_top_monitor.sv
// Purpose: port checker of the lane test block
// Assumes: apb answers in the cycle after setup
// Notes: bound to lbpc_top after the module
module lbpc_top_monitor #(
  parameter int SYNC_WORDS = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [lbpc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // lanes
  input wire logic [lbpc_pkg::LANES-1:0][lbpc_pkg::DATA_W-1:0] rx_data,
  input wire logic [lbpc_pkg::LANES-1:0][lbpc_pkg::DATA_W-1:0] tx_data,
  input wire logic [lbpc_pkg::LANES-1:0] tx_enable,
  input wire logic [lbpc_pkg::LANES-1:0] rx_enable,
  input wire logic [lbpc_pkg::LANES-1:0][1:0] loopback_sel,
  input wire logic [lbpc_pkg::LANES-1:0] tx_pll_lock,
  input wire logic [lbpc_pkg::LANES-1:0] rx_pll_lock,
  input wire logic [lbpc_pkg::LANES-1:0] receive_data_lock
);
  logic cmd_acc;
  assign cmd_acc = psel && penable && pready && pwrite &&
                   paddr == lbpc_pkg::ADDR_COMMAND;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_stop_cmd;
    cmd_acc && pwdata[lbpc_pkg::CMD_STOP_BIT];
  endsequence
  sequence s_rcf_held;
    loopback_sel[1] == lbpc_pkg::LB_RECOVERED_CLOCK_FAR ##1
    loopback_sel[1] == lbpc_pkg::LB_RECOVERED_CLOCK_FAR;
  endsequence
  AST_SETUP_ANSWER: assert property (s_setup |=> pready && penable)
    else $error("no answer in access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_MAPPED_OK: assert property (pready && paddr <= lbpc_pkg::ADDR_USER_PAT
    |-> !pslverr)
    else $error("error on mapped register");
  AST_REFUSED_ZERO: assert property (pslverr && !pwrite |->
    prdata == '0)
    else $error("refused read not zero");
  AST_RX_NEEDS_TX: assert property ((rx_enable & ~tx_enable) == '0)
    else $error("receiver on without transmitter");
  AST_STOP_ALL: assert property (s_stop_cmd |-> ##2 tx_enable == '0)
    else $error("lanes still on after stop");
  AST_RCF_COPY: assert property (s_rcf_held |->
    tx_data[1] == $past(rx_data[1]))
    else $error("far loopback word not copied");
  AST_START_CAUSE: assert property ($rose(tx_enable[0]) |->
    $past(cmd_acc && pwdata[lbpc_pkg::CMD_START_BIT]))
    else $error("lane started without command");
endmodule : lbpc_top_monitor

bind lbpc_top lbpc_top_monitor #(.SYNC_WORDS(SYNC_WORDS)) u_mon (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .rx_data(rx_data),
  .tx_data(tx_data), .tx_enable(tx_enable), .rx_enable(rx_enable),
  .loopback_sel(loopback_sel), .tx_pll_lock(tx_pll_lock),
  .rx_pll_lock(rx_pll_lock), .receive_data_lock(receive_data_lock));

// File: verification/lbpc_lane_peer.sv
// Purpose: lane peer that returns transmit words on receive
// Assumes: words on pclk, one register stage on the line
// Notes: far recovered-clock lanes get own words that change each cycle
module lbpc_lane_peer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // lane side
  input wire logic [lbpc_pkg::LANES-1:0][lbpc_pkg::DATA_W-1:0] tx_data,
  input wire logic [lbpc_pkg::LANES-1:0][1:0] loopback_sel,
  output logic [lbpc_pkg::LANES-1:0][lbpc_pkg::DATA_W-1:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [lbpc_pkg::DATA_W-1:0] word_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_r <= 20'h5a5a5;
      rx_data <= '0;
    end else begin
      word_r <= ~{word_r[18:0], word_r[19]};
      for (int l = 0; l < lbpc_pkg::LANES; l++) begin
        if (loopback_sel[l] == lbpc_pkg::LB_RECOVERED_CLOCK_FAR) begin
          rx_data[l] <= word_r ^ 20'(l);
        end else begin
          rx_data[l] <= tx_data[l];
        end
      end
    end
  end
endmodule : lbpc_lane_peer

// File: verification/lbpc_top_test.sv
// Purpose: self-checking bench of the lane test block
// Assumes: zero-wait apb slave, lanes returned by the peer model
// Notes: random words come from a 16-bit lfsr started at 902
module lbpc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [3:0][19:0] rx_data;
  logic [3:0][19:0] tx_data;
  logic [3:0] tx_enable;
  logic [3:0] rx_enable;
  logic [3:0][1:0] loopback_sel;
  logic [3:0] tx_pll_lock = 4'hf;
  logic [3:0] rx_pll_lock = 4'hf;
  logic [3:0] receive_data_lock = 4'hf;
  logic [15:0] seed = 16'h0386;
  logic [31:0] r;
  logic e;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;

  always #5 pclk = ~pclk;

  lbpc_top #(.SYNC_WORDS(8)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rx_data(rx_data),
    .tx_data(tx_data), .tx_enable(tx_enable), .rx_enable(rx_enable),
    .loopback_sel(loopback_sel), .tx_pll_lock(tx_pll_lock),
    .rx_pll_lock(rx_pll_lock), .receive_data_lock(receive_data_lock));

  lbpc_lane_peer u_peer (.pclk(pclk), .presetn(presetn),
    .tx_data(tx_data), .loopback_sel(loopback_sel), .rx_data(rx_data));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [19:0] static_word(input logic [1:0] m,
                                              input logic [19:0] u);
    case (m)
      lbpc_pkg::MODE_FIXED: return 20'haaaaa;
      lbpc_pkg::MODE_MAXRUN: return 20'hffc00;
      default: return u;
    endcase
  endfunction : static_word

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; request held until ready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test;
    end
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(lbpc_pkg::ADDR_LANE_CFG, 1'b0, 32'h0);
    check(r, 32'h0);
    apb(8'h40, 1'b1, 32'hffffffff);
    apb(8'h40, 1'b0, 32'h0);
    check({r[30:0], e}, 32'h1);
    for (int l = 0; l < 3; l++) begin
      seed = lfsr(seed);
      tx_pll_lock <= seed[3:0];
      rx_pll_lock <= seed[7:4];
      receive_data_lock <= seed[11:8];
      repeat (4) @(posedge pclk);
      apb(lbpc_pkg::ADDR_STATUS, 1'b0, 32'h0);
      check(32'(r[19:8]), 32'(seed[11:0]));
    end
    tx_pll_lock <= 4'hf;
    rx_pll_lock <= 4'hf;
    receive_data_lock <= 4'hf;
    apb(lbpc_pkg::ADDR_CONTROL, 1'b1, 32'h1);
    for (int o = 0; o < 5; o++) begin
      apb(lbpc_pkg::ADDR_LANE_CFG, 1'b1, 32'(o));
      apb(lbpc_pkg::ADDR_COMMAND, 1'b1, 32'h1);
      repeat (40) @(posedge pclk);
      apb(lbpc_pkg::ADDR_ERR_COUNT, 1'b0, 32'h0);
      check(r, 32'h0);
      apb(lbpc_pkg::ADDR_STATUS, 1'b0, 32'h0);
      check(32'(r[20]), 32'h1);
      apb(lbpc_pkg::ADDR_COMMAND, 1'b1, 32'h10000);
      repeat (10) @(posedge pclk);
      apb(lbpc_pkg::ADDR_ERR_COUNT, 1'b0, 32'h0);
      check(r, 32'h1);
      apb(lbpc_pkg::ADDR_COMMAND, 1'b1, 32'h100);
      apb(lbpc_pkg::ADDR_ERR_COUNT, 1'b0, 32'h0);
      check(r, 32'h0);
      apb(lbpc_pkg::ADDR_COMMAND, 1'b1, 32'h2);
      apb(lbpc_pkg::ADDR_STATUS, 1'b0, 32'h0);
      check(32'(r[3:0]), 32'h0);
    end
    tx_pll_lock <= 4'hd;
    for (int l = 0; l < 4; l++) begin
      apb(lbpc_pkg::ADDR_LANE_CFG + 8'(4 * l), 1'b1, 32'(l == 3 ? 5 : l));
    end
    apb(lbpc_pkg::ADDR_CONTROL, 1'b1, 32'hf);
    apb(lbpc_pkg::ADDR_COMMAND, 1'b1, 32'h1);
    repeat (3) @(posedge pclk);
    apb(lbpc_pkg::ADDR_STATUS, 1'b0, 32'h0);
    check(32'(r[7:0]), 32'ha5);
    check(32'({tx_enable, rx_enable}), 32'h55);
    apb(lbpc_pkg::ADDR_COMMAND, 1'b1, 32'h3);
    repeat (3) @(posedge pclk);
    check(32'(tx_enable), 32'h0);
    tx_pll_lock <= 4'hf;
    apb(lbpc_pkg::ADDR_LANE_CFG, 1'b1, 32'h0);
    for (int m = 1; m < 4; m++) begin
      seed = lfsr(seed);
      apb(lbpc_pkg::ADDR_USER_PAT, 1'b1, 32'({seed, seed[3:0]}));
      apb(lbpc_pkg::ADDR_CONTROL, 1'b1, 32'h1 | (32'(m) << 4));
      apb(lbpc_pkg::ADDR_COMMAND, 1'b1, 32'h1);
      repeat (4) @(posedge pclk);
      check(32'(tx_data[0]), 32'(static_word(2'(m), {seed, seed[3:0]})));
      check(32'({tx_enable[0], rx_enable[0]}), 32'h2);
      apb(lbpc_pkg::ADDR_STATUS, 1'b0, 32'h0);
      check(32'(r[15:8]), 32'hff);
      apb(lbpc_pkg::ADDR_COMMAND, 1'b1, 32'h2);
      repeat (3) @(posedge pclk);
      check(32'(tx_enable[0]), 32'h0);
    end
    for (int l = 0; l < 4; l++) begin
      apb(lbpc_pkg::ADDR_LANE_CFG + 8'h04, 1'b1, 32'(l) << 4);
      @(posedge pclk);
      check(32'(loopback_sel[1]), 32'(l));
    end
    repeat (2) @(posedge pclk);
    r = 32'(rx_data[1]);
    #1;
    check(32'(tx_data[1]), r);
    // phy-style reset only while no test runs
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check(32'({loopback_sel[1], tx_data[1]}), 32'h0);
    apb(lbpc_pkg::ADDR_LANE_CFG + 8'h04, 1'b0, 32'h0);
    check(r, 32'h0);
    stop_test;
  end
endmodule : lbpc_top_test
